// ---- core/hfs_consts.svh ----
// Offsets, field positions, reset values and timing counts of the fan safety register bank.
// Assumes a byte-indexed register map placed on 32-bit Avalon words (byte address = 4 * index).
`ifndef HFS_CONSTS_SVH
`define HFS_CONSTS_SVH

`define HFS_IDX_ZONE1_ABS 8'h6A
`define HFS_IDX_ZONE2_ABS 8'h6B
`define HFS_IDX_ZONE3_ABS 8'h6C
`define HFS_IDX_TEST_70 8'h70
`define HFS_IDX_TEST_71 8'h71
`define HFS_IDX_TEST_72 8'h72
`define HFS_IDX_TEST_73 8'h73
`define HFS_IDX_TEST_74 8'h74
`define HFS_IDX_TEST_75 8'h75
`define HFS_IDX_TEST_76 8'h76
`define HFS_IDX_TEST_77 8'h77
`define HFS_IDX_TEST_78 8'h78
`define HFS_IDX_TEST_79 8'h79
`define HFS_IDX_SPECIAL 8'h7C
`define HFS_IDX_VOLT_IRQ_EN 8'h7E
`define HFS_IDX_MON_CFG 8'h7F
`define HFS_IDX_TACH_IRQ_EN 8'h80
`define HFS_IDX_TACH_MAP 8'h81
// Extra registers for loose control and status bits
`define HFS_IDX_CONTROL 8'hA0
`define HFS_IDX_STATUS 8'hA1

`define HFS_RST_ABS 8'h64
`define HFS_RST_TEST_09 8'h09
`define HFS_RST_TEST_79 8'h00
`define HFS_RST_SPECIAL 8'hE0
`define HFS_RST_VOLT_IRQ_EN 8'hEC
`define HFS_RST_MON_CFG 8'h10
`define HFS_RST_TACH_IRQ_EN 8'h1E
`define HFS_RST_TACH_MAP 8'h24
`define HFS_RST_CONTROL 8'h00

`define HFS_ABS_DISABLED 8'h80
`define HFS_DUTY_FULL 8'hFF
`define HFS_DUTY_OFF 8'h00
`define HFS_TACH_NEVER 16'hFFFF
`define HFS_TEST_NIBBLE 8'h0F

`define HFS_SF_MONMODE 1
`define HFS_SF_ALERT_EN 2
`define HFS_SF_AVG_LO 5
`define HFS_CFG_DONE 2
`define HFS_CFG_TEMP_READINGS_VALID 3
`define HFS_CFG_SPINUP_CUT_ENABLE 4
`define HFS_CFG_INIT 7
`define HFS_CTL_LOCK 0
`define HFS_CTL_START 1

// Monitoring cycle length
`define HFS_CYCLE_US 100
`define HFS_CLK_MHZ 100
`define HFS_CYCLE_CYC (`HFS_CYCLE_US * `HFS_CLK_MHZ)

`endif

// ---- core/hfs_pkg.sv ----
// Types shared by the fan safety register bank.
// Assumes hfs_consts.svh supplies the numbers.
package hfs_pkg;
   typedef enum logic [1:0] {
      HFS_SCAN_IDLE = 2'b00,
      HFS_SCAN_RUN = 2'b01,
      HFS_SCAN_LAST = 2'b11
   } hfs_scan_t;

   typedef enum logic [1:0] {
      HFS_AVG_128_8 = 2'b00,
      HFS_AVG_16_1 = 2'b01,
      HFS_AVG_16 = 2'b10,
      HFS_AVG_32 = 2'b11
   } hfs_avg_t;
endpackage

// ---- core/hfs_scan_timer.sv ----
// Monitoring cycle sequencer: counts cycles while start is set and reports completion.
// Assumes a single clock; start comes from the register bank.
`timescale 1ns/1ns
`include "hfs_consts.svh"
module hfs_scan_timer #(
   parameter int CYCLE_CYC = `HFS_CYCLE_CYC
) (
   input wire logic clk, // System clock
   input wire logic rst, // Async reset, active high
   input wire logic soft_rst, // Soft reset pulse
   input wire logic start, // Monitoring enabled
   output logic cycle_end, // One-cycle pulse at end of each cycle
   output logic running // A cycle is in progress
);
   hfs_pkg::hfs_scan_t st_q, st_d;
   logic [31:0] cnt_q, cnt_d;

   // A cycle once begun completes even if start drops mid-way; only soft_rst or rst aborts it
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      cycle_end = 1'b0;
      unique case (st_q)
         hfs_pkg::HFS_SCAN_IDLE: begin
            if (start) begin
               st_d = hfs_pkg::HFS_SCAN_RUN;
               cnt_d = 32'h00000000;
            end
         end
         hfs_pkg::HFS_SCAN_RUN: begin
            cnt_d = cnt_q + 32'h00000001;
            if (cnt_q >= 32'(CYCLE_CYC - 2)) begin
               st_d = hfs_pkg::HFS_SCAN_LAST;
            end
         end
         hfs_pkg::HFS_SCAN_LAST: begin
            cycle_end = 1'b1;
            cnt_d = 32'h00000000;
            st_d = start ? hfs_pkg::HFS_SCAN_RUN : hfs_pkg::HFS_SCAN_IDLE;
         end
         default: st_d = hfs_pkg::HFS_SCAN_IDLE;
      endcase
      if (soft_rst) begin
         st_d = hfs_pkg::HFS_SCAN_IDLE;
         cnt_d = 32'h00000000;
      end
   end

   // State registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= hfs_pkg::HFS_SCAN_IDLE;
         cnt_q <= 32'h00000000;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
      end
   end

   assign running = (st_q != hfs_pkg::HFS_SCAN_IDLE);
endmodule

// ---- core/hfs_fan_guard.sv ----
// Over-temperature override and tach event gating for three fans and zones.
// Assumes temperatures and duties arrive already synchronous to clk.
`timescale 1ns/1ns
`include "hfs_consts.svh"
module hfs_fan_guard #(
   parameter int NFAN = 3
) (
   input wire logic clk, // System clock
   input wire logic rst, // Async reset, active high
   input wire logic [3*8-1:0] zone_temp, // Signed zone readings
   input wire logic [3*8-1:0] zone_abs_limit, // Signed absolute limits
   input wire logic [NFAN-1:0] fan_auto, // Fan in automatic mode
   input wire logic [NFAN-1:0] fan_disabled, // Fan disabled in fan config
   input wire logic [NFAN*8-1:0] pwm_duty_in, // Duty from fan control
   input wire logic [7:0] tach_map, // Tach to PWM association
   input wire logic [NFAN*16-1:0] tach_min, // Tach minimum limits
   input wire logic [NFAN-1:0] tach_fault, // Raw tach out-of-limit
   output logic [NFAN*8-1:0] pwm_duty_out, // Duty after override
   output logic [NFAN-1:0] tach_event, // Qualified tach events
   output logic overheat // Full-duty override active
);
   logic [NFAN*8-1:0] duty_q, duty_d;
   logic [NFAN-1:0] tev_q, tev_d;
   logic ovr_q, ovr_d;

   // Association field: 11 is reserved and names no PWM
   function automatic logic map_valid(input logic [1:0] f);
      return f != 2'b11; // [R22]
   endfunction

   // Override plus tach qualification; registered to keep outputs glitch free
   always_comb begin
      logic hot;
      logic [1:0] f;
      hot = 1'b0;
      f = 2'b00;
      for (int z = 0; z < 3; z++) begin
         if (zone_abs_limit[z*8 +: 8] != `HFS_ABS_DISABLED && // [R03]
             $signed(zone_temp[z*8 +: 8]) > $signed(zone_abs_limit[z*8 +: 8])) begin // [R04]
            hot = 1'b1;
         end
      end
      ovr_d = hot && (|fan_auto); // [R02]
      for (int p = 0; p < NFAN; p++) begin
         if (fan_disabled[p]) begin
            duty_d[p*8 +: 8] = pwm_duty_in[p*8 +: 8];
         end else if (ovr_d) begin
            duty_d[p*8 +: 8] = `HFS_DUTY_FULL; // [R02]
         end else begin
            duty_d[p*8 +: 8] = pwm_duty_in[p*8 +: 8];
         end
      end
      for (int t = 0; t < NFAN; t++) begin
         f = tach_map[t*2 +: 2]; // [R15]
         tev_d[t] = tach_fault[t] && map_valid(f) &&
                    tach_min[t*16 +: 16] != `HFS_TACH_NEVER; // [R17]
         for (int p = 0; p < NFAN; p++) begin
            if (map_valid(f) && f == 2'(p) &&
                (pwm_duty_in[p*8 +: 8] == `HFS_DUTY_OFF || fan_disabled[p])) begin
               tev_d[t] = 1'b0; // [R16]
            end
         end
      end
   end

   // Output registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         duty_q <= '0;
         tev_q <= '0;
         ovr_q <= 1'b0;
      end else begin
         duty_q <= duty_d;
         tev_q <= tev_d;
         ovr_q <= ovr_d;
      end
   end

   assign pwm_duty_out = duty_q;
   assign tach_event = tev_q;
   assign overheat = ovr_q;
endmodule

// ---- core/hfs_regs.sv ----
// Fan safety and monitor configuration register bank on an Avalon-MM slave.
// Assumes an Avalon master honouring waitrequest; temperature and tach inputs synchronous.
// Behaviour
// [R01] With the lock bit set, writes to this bank are dropped.
// [R02] In auto mode, any zone over its absolute limit drives enabled fans to full.
// [R03] A limit of 80h disables the over-temperature override for that zone.
// [R04] Limits are signed two's complement degrees, resetting to 64h.
// [R05] Special function bit 1 picks continuous (0) or cycle (1) monitoring.
// [R06] Special function bit 2 enables the active-low alert output, reset off.
// [R07] Averaging field decodes top-bit first; reset value 111.
// [R08] Voltage enable bit 0 lets voltage faults pull the alert low.
// [R09] Voltage enable bits 1-7 gate individual status setting; reset ECh.
// [R10] Cycle done reads 1 after start clears; toggles per cycle while started.
// [R11] Temperature ready sets after a cycle with start set; cleared by power good.
// [R12] Spin-up cut enable bit goes to fan logic, resets to 1.
// [R13] Writing configuration bit 7 restores all registers to defaults; self-clearing.
// [R14] Tach enable bit 0 gates alert, bits 1-3 gate status; reset 1Eh.
// [R15] Association register holds three 2-bit tach fields; reset 24h.
// [R16] No tach event while associated duty is 00h or fan disabled.
// [R17] A tach minimum of FFFFh never raises a tach event.
// [R18] Writes to test registers 70h-72h are ignored.
// [R19] Software leaves test registers and reserved bits at defaults.
// [R20] Special function bits 3 and 4 are reserved RW, reset 0; reset E0h.
// [R21] Software maps every tach to a PWM; undriven tachs disable their events.
// [R22] Association 00/01/10 select PWM 1/2/3; 11 selects none.
`timescale 1ns/1ns
`include "hfs_consts.svh"
module hfs_regs #(
   parameter int CYCLE_CYC = `HFS_CYCLE_CYC,
   parameter logic [7:0] TEST_RO_VALUE = 8'h00
) (
   input wire logic clk, // System clock, 100 MHz
   input wire logic rst, // Async reset, active high
   input wire logic [9:0] avs_address, // Byte address
   input wire logic avs_read, // Read request
   input wire logic avs_write, // Write request
   input wire logic [31:0] avs_writedata, // Write data
   input wire logic [3:0] avs_byteenable, // Byte lanes
   output logic [31:0] avs_readdata, // Read data
   output logic avs_waitrequest, // Stall
   output logic [1:0] avs_response, // 00 ok, 10 slave error
   input wire logic main_supply_good, // Main power good level
   input wire logic [3*8-1:0] zone_temp, // Zone readings
   input wire logic [2:0] fan_auto, // Fans in auto mode
   input wire logic [2:0] fan_disabled, // Fans disabled
   input wire logic [3*8-1:0] pwm_duty_in, // Duty from fan control
   input wire logic [3*16-1:0] tach_min, // Tach minimum limits
   input wire logic [2:0] tach_fault, // Raw tach faults
   input wire logic [7:1] volt_fault, // Raw voltage faults
   output logic [3*8-1:0] pwm_duty_out, // Duty after override
   output logic [7:1] volt_status_set, // Voltage status set enables
   output logic [3:1] tach_status_set, // Tach status set enables
   output logic alert_out_n, // Alert pin, active low
   output logic scan_style_select, // 1 = cycle monitoring
   output hfs_pkg::hfs_avg_t averaging_select, // Decoded averaging
   output logic spinup_cut_enable, // Spin-up reduction allowed
   output logic scan_active, // Monitoring cycle in progress
   output logic [7:0] tach_map_out // Association for fan logic
);
   logic [7:0] abs_q [3], abs_d [3];
   logic [7:0] t74_q, t74_d, t76_q, t76_d, t78_q, t78_d, t79_q, t79_d;
   logic [7:0] sf_q, sf_d, ven_q, ven_d, tven_q, tven_d, map_q, map_d;
   logic [6:4] cfg_q, cfg_d;
   logic lock_q, lock_d, start_q, start_d, done_q, done_d, temp_readings_valid_q, temp_readings_valid_d, pg_q, pg_d;
   logic ack_q, ack_d;
   logic [31:0] rd_q, rd_d;
   logic [1:0] rsp_q, rsp_d;
   logic cycle_end, running, overheat, soft_rst;
   logic [2:0] tach_event;
   logic [7:0] idx;
   logic wr, known;
   logic [7:0] rbyte;

   assign idx = avs_address[9:2];
   assign wr = avs_write && ack_q && avs_byteenable[0];

   // Index decode: sets only the response code; read mux and write case decode on their own
   function automatic logic is_mapped(input logic [7:0] i);
      return (i >= `HFS_IDX_ZONE1_ABS && i <= `HFS_IDX_ZONE3_ABS) ||
             (i >= `HFS_IDX_TEST_70 && i <= `HFS_IDX_TEST_79) ||
             i == `HFS_IDX_SPECIAL || i == `HFS_IDX_VOLT_IRQ_EN ||
             i == `HFS_IDX_MON_CFG || i == `HFS_IDX_TACH_IRQ_EN ||
             i == `HFS_IDX_TACH_MAP || i == `HFS_IDX_CONTROL || i == `HFS_IDX_STATUS;
   endfunction

   assign known = is_mapped(idx);
   assign soft_rst = wr && !lock_q && idx == `HFS_IDX_MON_CFG &&
                     avs_writedata[`HFS_CFG_INIT]; // [R13]

   hfs_scan_timer #(
      .CYCLE_CYC(CYCLE_CYC)
   ) u_scan (
      .clk(clk),
      .rst(rst),
      .soft_rst(soft_rst),
      .start(start_q),
      .cycle_end(cycle_end),
      .running(running)
   );

   hfs_fan_guard #(
      .NFAN(3)
   ) u_guard (
      .clk(clk),
      .rst(rst),
      .zone_temp(zone_temp),
      .zone_abs_limit({abs_q[2], abs_q[1], abs_q[0]}),
      .fan_auto(fan_auto),
      .fan_disabled(fan_disabled),
      .pwm_duty_in(pwm_duty_in),
      .tach_map(map_q),
      .tach_min(tach_min),
      .tach_fault(tach_fault),
      .pwm_duty_out(pwm_duty_out),
      .tach_event(tach_event),
      .overheat(overheat)
   );

   // Read mux; unmapped reads return zero with a slave error
   always_comb begin
      rbyte = 8'h00;
      unique case (idx)
         `HFS_IDX_ZONE1_ABS: rbyte = abs_q[0];
         `HFS_IDX_ZONE2_ABS: rbyte = abs_q[1];
         `HFS_IDX_ZONE3_ABS: rbyte = abs_q[2];
         `HFS_IDX_TEST_70, `HFS_IDX_TEST_71, `HFS_IDX_TEST_72: rbyte = TEST_RO_VALUE;
         `HFS_IDX_TEST_73, `HFS_IDX_TEST_75, `HFS_IDX_TEST_77: rbyte = `HFS_RST_TEST_09;
         `HFS_IDX_TEST_74: rbyte = t74_q;
         `HFS_IDX_TEST_76: rbyte = t76_q;
         `HFS_IDX_TEST_78: rbyte = t78_q;
         `HFS_IDX_TEST_79: rbyte = t79_q;
         `HFS_IDX_SPECIAL: rbyte = sf_q;
         `HFS_IDX_VOLT_IRQ_EN: rbyte = ven_q;
         `HFS_IDX_MON_CFG: rbyte = {1'b0, cfg_q[6:5], cfg_q[4], temp_readings_valid_q, done_q, 2'b00};
         `HFS_IDX_TACH_IRQ_EN: rbyte = tven_q;
         `HFS_IDX_TACH_MAP: rbyte = map_q;
         `HFS_IDX_CONTROL: rbyte = {6'h00, start_q, lock_q};
         `HFS_IDX_STATUS: rbyte = {5'h00, overheat, running, alert_out_n};
         default: rbyte = 8'h00;
      endcase
   end

   // Bus handshake: every access takes one wait cycle, answered the next
   always_comb begin
      ack_d = (avs_read || avs_write) && !ack_q;
      rd_d = rd_q;
      rsp_d = rsp_q;
      if (ack_d) begin
         rd_d = avs_read ? {24'h000000, rbyte} : 32'h00000000;
         rsp_d = known ? 2'b00 : 2'b10;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ack_q <= 1'b0;
         rd_q <= 32'h00000000;
         rsp_q <= 2'b00;
      end else begin
         ack_q <= ack_d;
         rd_q <= rd_d;
         rsp_q <= rsp_d;
      end
   end

   assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
   assign avs_readdata = rd_q;
   assign avs_response = rsp_q;

   // Register writes, soft reset and status bits
   always_comb begin
      logic [7:0] wd;
      logic ok;
      wd = avs_writedata[7:0];
      ok = wr && !lock_q; // [R01]
      abs_d = abs_q;
      t74_d = t74_q;
      t76_d = t76_q;
      t78_d = t78_q;
      t79_d = t79_q;
      sf_d = sf_q;
      ven_d = ven_q;
      cfg_d = cfg_q;
      tven_d = tven_q;
      map_d = map_q;
      lock_d = lock_q;
      start_d = start_q;
      done_d = done_q;
      temp_readings_valid_d = temp_readings_valid_q;
      pg_d = main_supply_good;
      if (ok) begin
         unique case (idx)
            `HFS_IDX_ZONE1_ABS: abs_d[0] = wd;
            `HFS_IDX_ZONE2_ABS: abs_d[1] = wd;
            `HFS_IDX_ZONE3_ABS: abs_d[2] = wd;
            `HFS_IDX_TEST_74: t74_d = wd & `HFS_TEST_NIBBLE;
            `HFS_IDX_TEST_76: t76_d = wd & `HFS_TEST_NIBBLE;
            `HFS_IDX_TEST_78: t78_d = wd & `HFS_TEST_NIBBLE;
            `HFS_IDX_TEST_79: t79_d = wd;
            `HFS_IDX_SPECIAL: sf_d = {wd[7:1], 1'b0}; // [R20]
            `HFS_IDX_VOLT_IRQ_EN: ven_d = wd;
            `HFS_IDX_MON_CFG: cfg_d = wd[6:4];
            `HFS_IDX_TACH_IRQ_EN: tven_d = {4'h0, wd[3:0]};
            `HFS_IDX_TACH_MAP: map_d = {2'b00, wd[5:0]}; // [R15]
            `HFS_IDX_CONTROL: begin
               lock_d = wd[`HFS_CTL_LOCK];
               start_d = wd[`HFS_CTL_START];
            end
            default: ; // 70h-72h and the rest: write has no effect [R18]
         endcase
      end
      // Done bit: 0 while a cycle runs after start, flips on each completion while start is set
      if (cycle_end) begin
         done_d = start_q ? !done_q : 1'b1; // [R10]
      end else if (ok && idx == `HFS_IDX_CONTROL && wd[`HFS_CTL_START] && !start_q) begin
         done_d = 1'b0;
      end else if (!start_q && !running) begin
         done_d = 1'b1; // [R10]
      end
      if (main_supply_good && !pg_q) begin
         temp_readings_valid_d = 1'b0; // [R11]
      end
      if (cycle_end && start_q) begin
         temp_readings_valid_d = 1'b1; // [R11]
      end
      if (soft_rst) begin
         abs_d = '{`HFS_RST_ABS, `HFS_RST_ABS, `HFS_RST_ABS}; // [R13]
         t74_d = `HFS_RST_TEST_09;
         t76_d = `HFS_RST_TEST_09;
         t78_d = `HFS_RST_TEST_09;
         t79_d = `HFS_RST_TEST_79;
         sf_d = `HFS_RST_SPECIAL;
         ven_d = `HFS_RST_VOLT_IRQ_EN;
         cfg_d = 3'(`HFS_RST_MON_CFG >> 4);
         tven_d = `HFS_RST_TACH_IRQ_EN;
         map_d = `HFS_RST_TACH_MAP;
         start_d = 1'b0;
         temp_readings_valid_d = 1'b0;
         done_d = 1'b1;
      end
   end

   // Register state; async reset loads the documented defaults
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         abs_q <= '{`HFS_RST_ABS, `HFS_RST_ABS, `HFS_RST_ABS}; // [R04]
         t74_q <= `HFS_RST_TEST_09;
         t76_q <= `HFS_RST_TEST_09;
         t78_q <= `HFS_RST_TEST_09;
         t79_q <= `HFS_RST_TEST_79;
         sf_q <= `HFS_RST_SPECIAL; // [R20]
         ven_q <= `HFS_RST_VOLT_IRQ_EN; // [R09]
         cfg_q <= 3'b001; // [R12]
         tven_q <= `HFS_RST_TACH_IRQ_EN; // [R14]
         map_q <= `HFS_RST_TACH_MAP;
         lock_q <= 1'b0;
         start_q <= 1'b0;
         done_q <= 1'b1;
         temp_readings_valid_q <= 1'b0;
         pg_q <= 1'b0;
      end else begin
         abs_q <= abs_d;
         t74_q <= t74_d;
         t76_q <= t76_d;
         t78_q <= t78_d;
         t79_q <= t79_d;
         sf_q <= sf_d;
         ven_q <= ven_d;
         cfg_q <= cfg_d;
         tven_q <= tven_d;
         map_q <= map_d;
         lock_q <= lock_d;
         start_q <= start_d;
         done_q <= done_d;
         temp_readings_valid_q <= temp_readings_valid_d;
         pg_q <= pg_d;
      end
   end

   // Averaging decode, top bit wins
   always_comb begin
      if (sf_q[7]) begin
         averaging_select = hfs_pkg::HFS_AVG_32; // [R07]
      end else if (sf_q[6]) begin
         averaging_select = hfs_pkg::HFS_AVG_16;
      end else if (sf_q[5]) begin
         averaging_select = hfs_pkg::HFS_AVG_16_1;
      end else begin
         averaging_select = hfs_pkg::HFS_AVG_128_8;
      end
   end

   // Alert pin: master enable and group enables; status gating by individual bits
   assign alert_out_n = !(sf_q[`HFS_SF_ALERT_EN] && // [R06]
                          ((ven_q[0] && |volt_fault) || // [R08]
                           (tven_q[0] && |tach_event))); // [R14]
   assign volt_status_set = volt_fault & ven_q[7:1]; // [R09]
   assign tach_status_set = tach_event & tven_q[3:1]; // [R14]
   assign scan_style_select = sf_q[`HFS_SF_MONMODE]; // [R05]
   assign spinup_cut_enable = cfg_q[`HFS_CFG_SPINUP_CUT_ENABLE]; // [R12]
   assign scan_active = running;
   assign tach_map_out = map_q;
endmodule

// ---- tb/hfs_regs_assertions.sv ----
// Port-level checks for the fan safety register bank.
// Assumes one clock domain; bound into every hfs_regs instance.
`timescale 1ns/1ns
module hfs_regs_assertions (
   input wire logic clk, // Clock
   input wire logic rst, // Async reset
   input wire logic [9:0] avs_address, // Byte address
   input wire logic avs_read, // Read request
   input wire logic avs_write, // Write request
   input wire logic avs_waitrequest, // Stall
   input wire logic [1:0] avs_response, // Response code
   input wire logic [3*8-1:0] zone_temp, // Zone readings
   input wire logic [2:0] fan_auto, // Auto fans
   input wire logic [2:0] fan_disabled, // Disabled fans
   input wire logic [3*8-1:0] pwm_duty_in, // Duty in
   input wire logic [3*8-1:0] pwm_duty_out, // Duty out
   input wire logic [3*16-1:0] tach_min, // Tach minimums
   input wire logic [2:0] tach_fault, // Raw tach faults
   input wire logic [7:1] volt_fault, // Raw voltage faults
   input wire logic [7:1] volt_status_set, // Voltage status
   input wire logic [3:1] tach_status_set // Tach status
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic req;
   // Either direction counts as a request
   assign req = avs_read | avs_write;
   sequence req_new;
      req && !$past(req);
   endsequence
   sequence req_held;
      req && avs_waitrequest;
   endsequence
   // Bus handshake: one wait cycle, then completion
   wait_first_a: assert property (req_new |-> avs_waitrequest)
      else $error("no wait on new request");
   ack_next_a: assert property (req_held |=> !avs_waitrequest)
      else $error("request not acknowledged");
   unmapped_err_a: assert property (avs_read && !avs_waitrequest &&
      avs_address[9:2] == 8'hFF |-> avs_response == 2'b10) else $error("unmapped read ok");
   // Override can only come from a zone above its limit with a fan in auto
   manual_pass_a: assert property (fan_auto == 3'b000
      |=> pwm_duty_out == $past(pwm_duty_in)) else $error("override without auto fan");
   disabled_pass_a: assert property (fan_disabled == 3'b111
      |=> pwm_duty_out == $past(pwm_duty_in)) else $error("disabled fan forced");
   cold_zone_a: assert property (zone_temp == 24'h808080
      |=> pwm_duty_out == $past(pwm_duty_in)) else $error("override at minimum reading");
   volt_gate_a: assert property ((volt_status_set & ~volt_fault) == 7'h00)
      else $error("voltage status without fault");
   // Tach events need a fault, a running duty and a real minimum
   tach_quiet_a: assert property ((tach_fault == 3'b000) [*3]
      |-> tach_status_set == 3'b000) else $error("tach status without fault");
   tach_idle_a: assert property ((pwm_duty_in == 24'h0 && fan_auto == 3'b000) [*3]
      |-> tach_status_set == 3'b000) else $error("tach status at zero duty");
   tach_never_a: assert property ((tach_min[15:0] == 16'hFFFF) [*3]
      |-> !tach_status_set[1]) else $error("tach status with max minimum");
endmodule
bind hfs_regs hfs_regs_assertions hfs_regs_assertions_i (.clk, .rst, .avs_address,
   .avs_read, .avs_write, .avs_waitrequest, .avs_response, .zone_temp, .fan_auto,
   .fan_disabled, .pwm_duty_in, .pwm_duty_out, .tach_min, .tach_fault, .volt_fault,
   .volt_status_set, .tach_status_set);

// ---- tb/tb_hfs_regs.sv ----
// Self-checking bench for the fan safety register bank.
// Assumes hfs_regs with a short monitoring cycle; the bench drives every port.
`timescale 1ns/1ns
module tb_hfs_regs;
   localparam int CYC = 20;
   logic clk, rst, rd_r, wr_r, good, wq, alert_n, style, spin, busy;
   logic [9:0] adr;
   logic [31:0] wd, ro, got;
   logic [3:0] be;
   logic [1:0] resp, gresp;
   logic [23:0] temp, din, dout;
   logic [2:0] fauto, fdis, tfault;
   logic [47:0] tmin;
   logic [7:1] vf, vset;
   logic [3:1] tset;
   logic [7:0] map;
   hfs_pkg::hfs_avg_t avg;
   int mismatches = 0;
   int tests_run = 0;
   hfs_regs #(.CYCLE_CYC(CYC)) hfs_regs_i (.clk(clk), .rst(rst), .avs_address(adr),
      .avs_read(rd_r), .avs_write(wr_r), .avs_writedata(wd), .avs_byteenable(be),
      .avs_readdata(ro), .avs_waitrequest(wq), .avs_response(resp),
      .main_supply_good(good), .zone_temp(temp), .fan_auto(fauto), .fan_disabled(fdis),
      .pwm_duty_in(din), .tach_min(tmin), .tach_fault(tfault), .volt_fault(vf),
      .pwm_duty_out(dout), .volt_status_set(vset), .tach_status_set(tset),
      .alert_out_n(alert_n), .scan_style_select(style), .averaging_select(avg),
      .spinup_cut_enable(spin), .scan_active(busy), .tach_map_out(map));
   // Free-running 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         mismatches++;
         $display("[ERR] %0t seen %h exp %h", $time, s, e);
      end
   endtask
   // One bus access; holds until waitrequest is seen low, then settles
   task automatic acc(input logic w, input logic [7:0] i, input logic [7:0] d);
      @(posedge clk);
      adr <= {i, 2'b00};
      wd <= {24'h0, d};
      rd_r <= ~w;
      wr_r <= w;
      @(posedge clk);
      while (wq !== 1'b0) @(posedge clk);
      got = ro;
      gresp = resp;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      @(negedge clk);
   endtask
   task automatic rdchk(input logic [7:0] i, input logic [7:0] e);
      acc(1'b0, i, 8'h00);
      chk(got, {24'h0, e});
   endtask
   task automatic summarize;
      $display("mismatches %0d tests_run %0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic t_reset;
      logic [7:0] ix[10] = '{8'h6A, 8'h6B, 8'h6C, 8'h73, 8'h74, 8'h79, 8'h7C, 8'h7E, 8'h80, 8'h81};
      logic [7:0] rv[10] = '{8'h64, 8'h64, 8'h64, 8'h09, 8'h09, 8'h00, 8'hE0, 8'hEC, 8'h1E, 8'h24};
      for (int k = 0; k < 10; k++) rdchk(ix[k], rv[k]);
      chk(spin, 1'b1);
      chk(alert_n, 1'b1);
      chk(map, 8'h24);
   endtask
   // Every averaging pattern, with the scan style bit riding along
   task automatic t_avg;
      hfs_pkg::hfs_avg_t e;
      for (int v = 0; v < 8; v++) begin
         e = v[2] ? hfs_pkg::HFS_AVG_32 : v[1] ? hfs_pkg::HFS_AVG_16 :
            v[0] ? hfs_pkg::HFS_AVG_16_1 : hfs_pkg::HFS_AVG_128_8;
         acc(1'b1, 8'h7C, {v[2:0], 3'h0, v[0], 1'b0});
         chk(avg, e);
         chk(style, v[0]);
      end
      acc(1'b1, 8'h7C, 8'hE0);
   endtask
   task automatic heat(input logic [23:0] t, input logic [2:0] a, input logic [23:0] e);
      @(posedge clk);
      temp <= t;
      fauto <= a;
      repeat (2) @(negedge clk);
      chk(dout, e);
   endtask
   task automatic t_heat;
      acc(1'b1, 8'h6A, 8'h32);
      acc(1'b1, 8'h6B, 8'hCE);
      acc(1'b1, 8'h6C, 8'h80);
      @(posedge clk);
      fdis <= 3'b010;
      din <= 24'h302010;
      heat(24'h7FCE32, 3'b100, 24'h302010);
      heat(24'h00CE90, 3'b100, 24'h302010);
      heat(24'h00CF00, 3'b100, 24'hFF20FF);
      heat(24'h00CF00, 3'b000, 24'h302010);
   endtask
   task automatic t_alert;
      @(posedge clk);
      vf <= 7'b0000011;
      @(negedge clk);
      chk(vset, 7'b0000010);
      chk(alert_n, 1'b1);
      acc(1'b1, 8'h7E, 8'hED);
      chk(alert_n, 1'b1);
      acc(1'b1, 8'h7C, 8'hE4);
      chk(alert_n, 1'b0);
      acc(1'b1, 8'h7E, 8'hEC);
      chk(alert_n, 1'b1);
      vf <= 7'h00;
      acc(1'b1, 8'h7C, 8'hE0);
   endtask
   task automatic tk(input logic [3:1] e);
      repeat (3) @(negedge clk);
      chk(tset, e);
   endtask
   task automatic t_tach;
      @(posedge clk);
      tfault <= 3'b111;
      fdis <= 3'b000;
      tk(3'b111);
      din[15:8] <= 8'h00;
      tk(3'b101);
      din[15:8] <= 8'h20;
      fdis <= 3'b100;
      tk(3'b011);
      fdis <= 3'b000;
      tmin[15:0] <= 16'hFFFF;
      tk(3'b110);
      tmin[15:0] <= 16'h0000;
      acc(1'b1, 8'h81, 8'h27);
      tk(3'b110);
      acc(1'b1, 8'h80, 8'h00);
      tk(3'b000);
      tfault <= 3'b000;
   endtask
   task automatic t_ro;
      acc(1'b1, 8'h70, 8'h5A);
      rdchk(8'h70, 8'h00);
      acc(1'b1, 8'h73, 8'h5A);
      rdchk(8'h73, 8'h09);
      acc(1'b0, 8'hFF, 8'h00);
      chk(gresp, 2'b10);
   endtask
   // Start a scan, see temperature ready, stop and see done, then power good
   task automatic t_cycle;
      acc(1'b1, 8'hA0, 8'h02);
      repeat (3 * CYC) @(negedge clk);
      acc(1'b0, 8'h7F, 8'h00);
      chk(got[3], 1'b1);
      acc(1'b1, 8'hA0, 8'h00);
      repeat (2 * CYC) @(negedge clk);
      acc(1'b0, 8'h7F, 8'h00);
      chk(got[2], 1'b1);
      chk(busy, 1'b0);
      good <= 1'b1;
      acc(1'b0, 8'h7F, 8'h00);
      chk(got[3], 1'b0);
   endtask
   task automatic t_soft;
      acc(1'b1, 8'h7C, 8'hE6);
      acc(1'b1, 8'h7F, 8'h90);
      rdchk(8'h7C, 8'hE0);
      rdchk(8'h81, 8'h24);
      acc(1'b0, 8'h7F, 8'h00);
      chk(got[7], 1'b0);
   endtask
   // Lock holds until hard reset, even against unlocking
   task automatic t_lock;
      acc(1'b1, 8'hA0, 8'h01);
      acc(1'b1, 8'h6A, 8'h11);
      rdchk(8'h6A, 8'h64);
      acc(1'b1, 8'hA0, 8'h00);
      acc(1'b1, 8'h6A, 8'h11);
      rdchk(8'h6A, 8'h64);
   endtask
   // Watchdog sized well above the expected run
   initial begin
      #200000;
      mismatches++;
      summarize();
   end
   // Main sequence
   initial begin
      rst = 1'b1;
      {rd_r, wr_r, good, adr, wd, temp, din, fauto, fdis, tfault, tmin, vf} = '0;
      be = 4'hF;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_avg();
      t_heat();
      t_alert();
      t_tach();
      t_ro();
      t_cycle();
      t_soft();
      t_lock();
      summarize();
   end
endmodule
